// ===== pkg/rxaf_pkg.sv
// Constants, field layouts and carrier types of the receive address and pattern filter
package rxaf_pkg;
    // ------------------------------------------------------------
    // Host register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h40;
    localparam logic [7:0] DATA_OFFSET = 8'h4c;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int SEL_W = 10;
    localparam int CTL_MASTER = 31;
    localparam int CTL_ACC_BCAST = 30;
    localparam int CTL_ACC_MCAST = 29;
    localparam int CTL_ACC_UCAST = 28;
    localparam int CTL_MHASH = 27;
    localparam int CTL_UHASH = 26;
    localparam int CTL_EXACT = 25;
    localparam int CTL_PAT_LSB = 21;
    localparam logic [31:0] CTRL_WMASK = 32'hffe0_03ff;

    // ------------------------------------------------------------
    // Internal locations behind the select field
    // ------------------------------------------------------------
    localparam logic [9:0] SEL_EXACT_10 = 10'h000;
    localparam logic [9:0] SEL_EXACT_32 = 10'h002;
    localparam logic [9:0] SEL_EXACT_54 = 10'h004;
    localparam logic [9:0] SEL_COUNT_10 = 10'h006;
    localparam logic [9:0] SEL_COUNT_32 = 10'h008;
    localparam logic [9:0] SEL_PASS_10 = 10'h00a;
    localparam logic [9:0] SEL_PASS_32 = 10'h00c;
    localparam logic [9:0] SEL_PASS_54 = 10'h00e;
    localparam int SEL_RAM_BIT = 9;

    // ------------------------------------------------------------
    // Filter memory layout (18-bit word index relative to 200h)
    // ------------------------------------------------------------
    localparam int RAM_WORDS = 256;
    localparam int RAM_AW = 8;
    localparam int RAM_DW = 18;
    localparam int MASK0_BIT = 16;
    localparam int MASK1_BIT = 17;
    localparam int NUM_PAT = 4;
    localparam logic [3:0][7:0] PAT_BASE = {8'h81, 8'h80, 8'h41, 8'h40};
    localparam int PAT_DEPTH_LO = 64;
    localparam int PAT_DEPTH_HI = 128;

    // ------------------------------------------------------------
    // Destination address and hashing
    // ------------------------------------------------------------
    localparam int DA_BYTES = 6;
    localparam logic [7:0] DA_LEN = 8'h06;
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam int HASH_IDX_W = 9;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sof;
        logic eof;
        logic [7:0] data;
    } rxaf_rx_beat_s;

    typedef struct packed {
        logic master;
        logic acc_bcast;
        logic acc_mcast;
        logic acc_ucast;
        logic mhash;
        logic uhash;
        logic exact;
        logic [NUM_PAT-1:0] pat_en;
        logic [SEL_W-1:0] sel;
    } rxaf_ctrl_s;
endpackage

// ===== core/rxaf_pattern_match.sv
// One pattern buffer comparator, tracking match state across a received packet
`timescale 1ns/1ps
`default_nettype none
module rxaf_pattern_match #(
    parameter int DEPTH = 64
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_step,
    input wire logic i_start,
    input wire logic [7:0] i_pos,
    input wire logic [7:0] i_byte,
    input wire logic [17:0] i_word,
    input wire logic [7:0] i_count,
    output logic o_match
);
    if (DEPTH < 2 || DEPTH > 128 || DEPTH % 2 != 0) begin : g_bad_depth
        $error("rxaf_pattern_match: unsupported DEPTH");
    end

    // ------------------------------------------------------------
    // Byte compare
    // ------------------------------------------------------------
    logic ok_q;
    logic seen_q;
    logic in_range;
    logic masked;
    logic [7:0] pat_byte;
    logic hit;
    logic ok_base;
    logic seen_base;

    assign in_range = (i_pos < i_count) && (int'(i_pos) < DEPTH);
    assign pat_byte = i_pos[0] ? i_word[15:8] : i_word[7:0];
    assign masked = i_pos[0] ? i_word[rxaf_pkg::MASK1_BIT] : i_word[rxaf_pkg::MASK0_BIT];
    assign hit = masked || (pat_byte == i_byte);
    assign ok_base = i_start ? 1'b1 : ok_q;
    assign seen_base = i_start ? 1'b0 : seen_q;
    assign o_match = ok_q && seen_q;

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ok_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (i_step) begin
            ok_q <= ok_base && (!in_range || hit);
            seen_q <= seen_base || (in_range && (i_pos == i_count - 8'h01));
        end
    end
endmodule // rxaf_pattern_match
`default_nettype wire

// ===== core/rxaf_filter.sv
// Receive packet qualification with indirect filter register and memory access
`timescale 1ns/1ps
`default_nettype none
module rxaf_filter (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_rx_valid,
    input wire rxaf_pkg::rxaf_rx_beat_s i_rx_beat,
    output logic o_rx_done,
    output logic o_rx_accept
);
    // ------------------------------------------------------------
    // Control register and decoded fields
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    rxaf_pkg::rxaf_ctrl_s ctl;
    logic wr_ctrl;
    logic wr_data;
    logic sel_ram;
    logic [rxaf_pkg::RAM_AW-1:0] sel_idx;

    assign wr_ctrl = i_reg_wr && (i_reg_addr == rxaf_pkg::CTRL_OFFSET);
    assign wr_data = i_reg_wr && (i_reg_addr == rxaf_pkg::DATA_OFFSET);
    assign ctl.master = ctrl_q[rxaf_pkg::CTL_MASTER];
    assign ctl.acc_bcast = ctrl_q[rxaf_pkg::CTL_ACC_BCAST];
    assign ctl.acc_mcast = ctrl_q[rxaf_pkg::CTL_ACC_MCAST];
    assign ctl.acc_ucast = ctrl_q[rxaf_pkg::CTL_ACC_UCAST];
    assign ctl.mhash = ctrl_q[rxaf_pkg::CTL_MHASH];
    assign ctl.uhash = ctrl_q[rxaf_pkg::CTL_UHASH];
    assign ctl.exact = ctrl_q[rxaf_pkg::CTL_EXACT];
    assign ctl.pat_en = ctrl_q[rxaf_pkg::CTL_PAT_LSB +: rxaf_pkg::NUM_PAT];
    assign ctl.sel = ctrl_q[rxaf_pkg::SEL_W-1:0];
    assign sel_ram = ctl.sel[rxaf_pkg::SEL_RAM_BIT];
    assign sel_idx = ctl.sel[rxaf_pkg::RAM_AW:1];

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ctrl_q <= rxaf_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= i_reg_wdata & rxaf_pkg::CTRL_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Internal filter registers and memory
    // ------------------------------------------------------------
    logic [5:0][7:0] exact_q;
    logic [5:0][7:0] pass_q;
    logic [3:0][7:0] count_q;
    logic [rxaf_pkg::RAM_DW-1:0] mem [rxaf_pkg::RAM_WORDS];
    logic wr_ex0, wr_ex1, wr_ex2, wr_cnt0, wr_cnt1, wr_pw0, wr_pw1, wr_pw2, wr_mem;

    assign wr_ex0 = wr_data && (ctl.sel == rxaf_pkg::SEL_EXACT_10);
    assign wr_ex1 = wr_data && (ctl.sel == rxaf_pkg::SEL_EXACT_32);
    assign wr_ex2 = wr_data && (ctl.sel == rxaf_pkg::SEL_EXACT_54);
    assign wr_cnt0 = wr_data && (ctl.sel == rxaf_pkg::SEL_COUNT_10);
    assign wr_cnt1 = wr_data && (ctl.sel == rxaf_pkg::SEL_COUNT_32);
    assign wr_pw0 = wr_data && (ctl.sel == rxaf_pkg::SEL_PASS_10);
    assign wr_pw1 = wr_data && (ctl.sel == rxaf_pkg::SEL_PASS_32);
    assign wr_pw2 = wr_data && (ctl.sel == rxaf_pkg::SEL_PASS_54);
    assign wr_mem = wr_data && sel_ram;

    // Lower-numbered octet in bits 7:0 of every pair
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            exact_q <= '0;
            pass_q <= '0;
            count_q <= '0;
        end else begin
            if (wr_ex0) exact_q[1:0] <= i_reg_wdata[15:0];
            if (wr_ex1) exact_q[3:2] <= i_reg_wdata[15:0];
            if (wr_ex2) exact_q[5:4] <= i_reg_wdata[15:0];
            if (wr_cnt0) count_q[1:0] <= i_reg_wdata[15:0];
            if (wr_cnt1) count_q[3:2] <= i_reg_wdata[15:0];
            if (wr_pw0) pass_q[1:0] <= i_reg_wdata[15:0];
            if (wr_pw1) pass_q[3:2] <= i_reg_wdata[15:0];
            if (wr_pw2) pass_q[5:4] <= i_reg_wdata[15:0];
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < rxaf_pkg::RAM_WORDS; i++) mem[i] <= '0;
        end else if (wr_mem) begin
            mem[sel_idx] <= i_reg_wdata[rxaf_pkg::RAM_DW-1:0];
        end
    end

    // ------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------
    logic [31:0] loc_data;
    logic [31:0] rd_data;

    always_comb begin
        loc_data = '0;
        if (sel_ram) begin
            loc_data = 32'(mem[sel_idx]);
        end else begin
            case (ctl.sel)
                rxaf_pkg::SEL_EXACT_10: loc_data = {16'h0000, exact_q[1:0]};
                rxaf_pkg::SEL_EXACT_32: loc_data = {16'h0000, exact_q[3:2]};
                rxaf_pkg::SEL_EXACT_54: loc_data = {16'h0000, exact_q[5:4]};
                rxaf_pkg::SEL_COUNT_10: loc_data = {16'h0000, count_q[1:0]};
                rxaf_pkg::SEL_COUNT_32: loc_data = {16'h0000, count_q[3:2]};
                rxaf_pkg::SEL_PASS_10: loc_data = {16'h0000, pass_q[1:0]};
                rxaf_pkg::SEL_PASS_32: loc_data = {16'h0000, pass_q[3:2]};
                rxaf_pkg::SEL_PASS_54: loc_data = {16'h0000, pass_q[5:4]};
                default: loc_data = '0;
            endcase
        end
    end

    assign rd_data = (i_reg_addr == rxaf_pkg::CTRL_OFFSET) ? ctrl_q :
                     (i_reg_addr == rxaf_pkg::DATA_OFFSET) ? loc_data : '0;

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= rxaf_pkg::DATA_RESET;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) o_reg_rdata <= rd_data;
        end
    end

    // ------------------------------------------------------------
    // Receive byte tracking, destination capture and CRC
    // ------------------------------------------------------------
    logic [7:0] pos_q;
    logic [7:0] cur_pos;
    logic in_da;
    logic [5:0][7:0] da_q;
    logic [31:0] crc_q;
    logic [31:0] crc_base;
    logic [31:0] crc_next;
    logic pend_q;

    assign cur_pos = i_rx_beat.sof ? 8'h00 : pos_q;
    assign in_da = cur_pos < rxaf_pkg::DA_LEN;
    assign crc_base = i_rx_beat.sof ? rxaf_pkg::CRC_INIT : crc_q;

    always_comb begin
        crc_next = crc_base;
        for (int b = 0; b < 8; b++) begin
            crc_next = (crc_next[0] ^ i_rx_beat.data[b]) ?
                       ((crc_next >> 1) ^ rxaf_pkg::CRC_POLY) : (crc_next >> 1);
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            pos_q <= '0;
            da_q <= '0;
            crc_q <= rxaf_pkg::CRC_INIT;
            pend_q <= 1'b0;
        end else begin
            pend_q <= i_rx_valid && i_rx_beat.eof;
            if (i_rx_valid) begin
                pos_q <= (cur_pos == 8'hff) ? cur_pos : cur_pos + 8'h01;
                if (in_da) begin
                    da_q[cur_pos[2:0]] <= i_rx_beat.data;
                    crc_q <= crc_next;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pattern buffers
    // ------------------------------------------------------------
    logic [rxaf_pkg::NUM_PAT-1:0] pat_match;

    for (genvar g = 0; g < rxaf_pkg::NUM_PAT; g++) begin : g_pat
        logic [rxaf_pkg::RAM_AW-1:0] widx;
        assign widx = rxaf_pkg::PAT_BASE[g] + {cur_pos[6:1], 1'b0};
        rxaf_pattern_match #(
            .DEPTH((g < 2) ? rxaf_pkg::PAT_DEPTH_LO : rxaf_pkg::PAT_DEPTH_HI)
        ) u_match (
            .i_clock(i_clock),
            .i_reset(i_reset),
            .i_step(i_rx_valid),
            .i_start(i_rx_beat.sof),
            .i_pos(cur_pos),
            .i_byte(i_rx_beat.data),
            .i_word(mem[widx]),
            .i_count(count_q[g]),
            .o_match(pat_match[g])
        );
    end

    // ------------------------------------------------------------
    // Acceptance decision
    // ------------------------------------------------------------
    logic da_full;
    logic is_bcast;
    logic is_mcast;
    logic is_ucast;
    logic exact_hit;
    logic [rxaf_pkg::HASH_IDX_W-1:0] hash_idx;
    logic [rxaf_pkg::RAM_DW-1:0] hash_word;
    logic hash_bit;
    logic accept;

    assign da_full = pos_q >= rxaf_pkg::DA_LEN;
    assign is_bcast = da_full && (da_q == '1);
    assign is_mcast = da_full && da_q[0][0];
    assign is_ucast = da_full && !da_q[0][0];
    assign exact_hit = da_full && (da_q == exact_q);
    assign hash_idx = ~crc_q[rxaf_pkg::HASH_IDX_W-1:0];
    assign hash_word = mem[{3'b000, hash_idx[8:4]}];
    assign hash_bit = hash_word[hash_idx[3:0]];
    assign accept = ctl.master && (
        (is_bcast && ctl.acc_bcast) ||
        (is_mcast && ctl.acc_mcast) ||
        (is_ucast && ctl.acc_ucast) ||
        (ctl.exact && exact_hit) ||
        (is_mcast && ctl.mhash && hash_bit) ||
        (is_ucast && ctl.uhash && hash_bit) ||
        |(ctl.pat_en & pat_match));

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_rx_done <= 1'b0;
            o_rx_accept <= 1'b0;
        end else begin
            o_rx_done <= pend_q;
            o_rx_accept <= pend_q && accept;
        end
    end
endmodule // rxaf_filter
`default_nettype wire

// ===== verification/rxaf_filter_checker.sv
// Concurrent checks on the receive filter ports
`timescale 1ns/1ps
`default_nettype none
module rxaf_filter_checker (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_rx_valid,
    input wire rxaf_pkg::rxaf_rx_beat_s i_rx_beat,
    input wire logic o_rx_done,
    input wire logic o_rx_accept
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // --------------------------------
    // Helper state
    // --------------------------------
    logic master_q;
    logic ctrl_wr;
    logic ctrl_rd;
    logic map_rd;
    assign ctrl_wr = i_reg_wr && (i_reg_addr == rxaf_pkg::CTRL_OFFSET);
    assign ctrl_rd = i_reg_rd && (i_reg_addr == rxaf_pkg::CTRL_OFFSET);
    assign map_rd = ctrl_rd || (i_reg_addr == rxaf_pkg::DATA_OFFSET);
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            master_q <= 1'b0;
        end else if (ctrl_wr) begin
            master_q <= i_reg_wdata[rxaf_pkg::CTL_MASTER];
        end
    end
    sequence s_eof_taken;
        i_rx_valid && i_rx_beat.eof;
    endsequence
    sequence s_decision;
        ##2 o_rx_done;
    endsequence
    // --------------------------------
    // Assertions
    // --------------------------------
    AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered next cycle");
    AST_RVALID_CAUSE: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read valid without a read");
    AST_RDATA_HOLD: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (i_reg_rd && !map_rd |=> o_reg_rdata == 32'h0)
        else $error("unmapped offset read not zero");
    AST_CTRL_UNUSED: assert property (ctrl_rd |=> o_reg_rdata[20:10] == 11'h000)
        else $error("control unused bits not zero");
    AST_DONE_LAT: assert property (s_eof_taken |-> s_decision)
        else $error("decision not given two cycles after last byte");
    AST_DONE_CAUSE: assert property (o_rx_done |-> $past(i_rx_valid && i_rx_beat.eof, 2))
        else $error("decision without a last byte");
    AST_ACCEPT_QUAL: assert property (o_rx_accept |-> o_rx_done)
        else $error("accept outside decision");
    AST_MASTER_OFF: assert property (o_rx_done && !master_q && !$past(master_q) |-> !o_rx_accept)
        else $error("accept with filter disabled");
endmodule // rxaf_filter_checker
bind rxaf_filter rxaf_filter_checker i_chk (.i_clock(i_clock), .i_reset(i_reset),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_rx_valid(i_rx_valid), .i_rx_beat(i_rx_beat), .o_rx_done(o_rx_done),
    .o_rx_accept(o_rx_accept));
`default_nettype wire

// ===== verification/rxaf_rx_source.sv
// Receive byte source in place of the MAC receive path
`timescale 1ns/1ps
`default_nettype none
module rxaf_rx_source (
    input wire logic i_clock,
    output var logic o_rx_valid,
    output var rxaf_pkg::rxaf_rx_beat_s o_rx_beat
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_beat = '0;
    end
    // Eight bytes, top byte first, idle gap after byte 2; idle data toggles
    task automatic send(input logic [63:0] pkt);
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clock);
            if (i == 3) begin
                o_rx_valid <= 1'b0;
                o_rx_beat <= {2'b00, ~o_rx_beat.data};
                @(posedge i_clock);
            end
            o_rx_valid <= 1'b1;
            o_rx_beat <= {i == 0, i == 7, pkt[63 - 8 * i -: 8]};
        end
        @(posedge i_clock);
        o_rx_valid <= 1'b0;
        o_rx_beat <= {2'b00, ~o_rx_beat.data};
    endtask
endmodule // rxaf_rx_source
`default_nettype wire

// ===== verification/rxaf_filter_tb.sv
// Self-checking bench for the receive filter
`timescale 1ns/1ps
`default_nettype none
module rxaf_filter_tb;
    logic i_clock, i_reset, wr, rd, rvalid, rxv, done, acc;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, ctl_en;
    logic [8:0] hx;
    rxaf_pkg::rxaf_rx_beat_s beat;
    int error_cnt, check_count, cycles;
    logic [2:0] cls [3] = '{3'b100, 3'b110, 3'b001};
    localparam logic [63:0] BC = 64'hffff_ffff_ffff_1234;
    localparam logic [63:0] MC = 64'h0100_5e00_0001_1234;
    localparam logic [63:0] UC = 64'h0200_0000_0001_1234;
    localparam logic [63:0] P0X = 64'h0200_7701_0402_aabb;
    localparam logic [7:0] CA = rxaf_pkg::CTRL_OFFSET;
    localparam logic [7:0] DA = rxaf_pkg::DATA_OFFSET;
    rxaf_filter i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_rx_valid(rxv), .i_rx_beat(beat), .o_rx_done(done), .o_rx_accept(acc));
    rxaf_rx_source i_src (.i_clock(i_clock), .o_rx_valid(rxv), .o_rx_beat(beat));
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    // --------------------------------
    // Access tasks
    // --------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clock);
        rd <= 1'b0;
        #1;
        chk({rvalid, rdata}, {1'b1, exp});
    endtask
    task automatic set_ctl(input logic [31:0] v);
        ctl_en = v;
        wrr(CA, v);
    endtask
    task automatic fw(input logic [9:0] sel, input logic [31:0] d);
        wrr(CA, ctl_en | {22'h0, sel});
        wrr(DA, d);
    endtask
    task automatic fr(input logic [9:0] sel, input logic [31:0] exp);
        wrr(CA, ctl_en | {22'h0, sel});
        rdr(DA, exp);
    endtask
    task automatic pkt(input logic [63:0] p, input logic exp);
        int n = 0;
        i_src.send(p);
        while (done !== 1'b1 && n < 6) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        chk({31'h0, done, acc}, {31'h0, 1'b1, exp});
    endtask
    function automatic logic [8:0] hidx(input logic [47:0] da);
        logic [31:0] c = 32'hffff_ffff;
        for (int i = 0; i < 6; i++) begin
            c = c ^ {24'h0, da[47 - 8 * i -: 8]};
            for (int j = 0; j < 8; j++) begin
                c = c[0] ? ((c >> 1) ^ 32'hedb8_8320) : (c >> 1);
            end
        end
        return ~c[8:0];
    endfunction
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // --------------------------------
    // Test sequence
    // --------------------------------
    initial begin
        i_reset = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        ctl_en = 32'h0;
        repeat (10) @(posedge i_clock);
        i_reset <= 1'b0;
        rdr(CA, rxaf_pkg::CTRL_RESET);
        rdr(DA, rxaf_pkg::DATA_RESET);
        for (int k = 0; k < 8; k++) fw(10'(2 * k), 32'(k * 32'h1111 + 32'h0102));
        for (int k = 0; k < 8; k++) fr(10'(2 * k), 32'(k * 32'h1111 + 32'h0102));
        fw(10'h280, 32'hffff_0204);
        fr(10'h280, 32'h0003_0204);
        fr(10'h281, 32'h0003_0204);
        fw(10'h3fe, 32'h0001_abcd);
        fr(10'h3fe, 32'h0001_abcd);
        fw(10'h010, 32'h0000_beef);
        fr(10'h010, 32'h0);
        rdr(8'h44, 32'h0);
        wrr(CA, 32'hffff_ffff);
        rdr(CA, 32'hffe0_03ff);
        set_ctl(32'h0);
        fw(10'h000, 32'h0008);
        fw(10'h002, 32'h0717);
        fw(10'h004, 32'h5528);
        set_ctl(32'h8200_0000);
        pkt(64'h0800_1707_2855_0000, 1'b1);
        pkt(64'h0800_1707_2854_0000, 1'b0);
        pkt(64'h5528_0717_0008_0000, 1'b0);
        for (int k = 0; k < 3; k++) begin
            set_ctl(32'h8000_0000 | (32'h4000_0000 >> k));
            pkt(BC, cls[k][2]);
            pkt(MC, cls[k][1]);
            pkt(UC, cls[k][0]);
        end
        set_ctl(32'h4000_0000);
        pkt(BC, 1'b0);
        set_ctl(32'h0);
        fw(10'h006, 32'h0406);
        fw(10'h008, 32'h0406);
        fw(10'h280, 32'h0002);
        fw(10'h284, 32'h0103);
        fw(10'h288, 32'h0204);
        fw(10'h302, 32'h3032);
        fw(10'h306, 32'h3133);
        set_ctl(32'h8120_0000);
        pkt(64'h0200_0301_0402_aabb, 1'b1);
        pkt(64'h3230_3331_0000_0000, 1'b1);
        pkt(P0X, 1'b0);
        fw(10'h284, 32'h0001_0103);
        pkt(P0X, 1'b1);
        set_ctl(32'h0);
        hx = hidx(MC[63:16]);
        fw(10'h200 + {4'h0, hx[8:4], 1'b0}, 32'h1 << hx[3:0]);
        set_ctl(32'h8800_0000);
        pkt(MC, 1'b1);
        fw(10'h200 + {4'h0, hx[8:4], 1'b0}, 32'h0);
        pkt(MC, 1'b0);
        hx = hidx(UC[63:16]);
        fw(10'h200 + {4'h0, hx[8:4], 1'b0}, 32'h1 << hx[3:0]);
        set_ctl(32'h8400_0000);
        pkt(UC, 1'b1);
        pkt(MC, 1'b0);
        set_ctl(32'h0);
        fw(10'h282, 32'h1012);
        fw(10'h286, 32'h1113);
        fw(10'h28a, 32'h1214);
        fw(10'h300, 32'h2022);
        fw(10'h304, 32'h2123);
        fw(10'h308, 32'h2224);
        set_ctl(32'h8040_0000);
        pkt(64'h1210_1311_0000_0000, 1'b1);
        pkt(64'h0200_0301_0402_aabb, 1'b0);
        set_ctl(32'h8080_0000);
        pkt(64'h2220_2321_2422_0000, 1'b1);
        pkt(64'h1210_1311_0000_0000, 1'b0);
        summarize();
    end
endmodule // rxaf_filter_tb
`default_nettype wire
